// File: drive_state_control_word.sv
// Summary of operation
// R1 - Status bit 8 shows whether a halt request is currently active.
// R2 - Status bit 9 is 1 when fieldbus owns motion commands, else 0.
// R3 - Parameter reads and writes over the fieldbus work regardless of bit 9.
// R4 - Status bits 10 and 12 carry flags defined by the active mode.
// R5 - Status bit 13 set on errors needing removal; reaction follows class.
// R6 - Status bit 14 clears when an operating mode starts.
// R7 - After end or interrupt, bit 14 returns to 1 only at standstill.
// R8 - Mode started right after another keeps bit 14 at 0.
// R9 - Status bit 15 set on valid zero point, kept while stage disabled.
// R10 - Enable input rising edge enables the stage, falling edge disables it.
// R11 - Fault reset input rising edge: fault to disabled, quick stop to enabled.
// R12 - Control word bits: switch on, voltage, quick stop, operation, fault reset, halt.
// R13 - Master writes zeros to control word bits 9 to 15.
// R14 - Shutdown 110 to ready, 0111 to switched on, bit1 low disables.
// R15 - Quick stop bit2 low, 1111 enables operation, bit7 rise resets fault.
// R16 - Control bit 8 high requests a halt with halt deceleration.
// R17 - Enabling the power stage starts the selected operating mode; entering fault reaction from a disabled state enables it with no mode start.
// R18 - Mode selector takes codes -4,-1,1,3,6,8 and acts at once.
// R19 - Read-only register shows the active mode in the same codes.
// R20 - Operating state encoded in status bits 0,1,2,3,5,6.
// R21 - Status bit 7 follows class-0 warning, held 100 ms, fault reset clears.
// R22 - Reserved status bit 11 reads 0; reserved control bits ignored.
`timescale 1ns/1ps
`include "drive_state_defines.svh"
module drive_state_control_word
  import drive_state_pkg::*;
#(
  parameter int unsigned WARN_HOLD_CYCLES = `WARN_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Fieldbus parameter access
  input wire logic i_par_valid,
  input wire logic i_par_write,
  input wire logic [15:0] i_par_addr,
  input wire logic [15:0] i_par_wdata,
  output logic [15:0] o_par_rdata,
  output logic o_par_ack,
  output logic o_par_err,
  // Discrete signal inputs (pins)
  input wire logic i_enable_pin,
  input wire logic i_fault_reset_pin,
  // Drive internals
  input wire logic i_remote,
  input wire logic i_dc_bus_ok,
  input wire logic i_warning_class0,
  input wire logic i_error_event,
  input wire logic [2:0] i_error_class,
  input wire logic i_error_present,
  input wire logic i_fault_reaction_done,
  input wire logic i_standstill,
  input wire logic i_mode_done,
  input wire logic i_mode_flag_a,
  input wire logic i_mode_flag_b,
  input wire logic i_zero_point_set,
  input wire logic i_zero_point_lost,
  // Drive control outputs
  output logic [15:0] o_status_word,
  output logic [15:0] o_mode_active,
  output logic o_power_stage_en,
  output logic o_mode_start,
  output logic o_halt,
  output logic o_quick_stop,
  output logic o_fault_reaction
);

  drive_state_t state_ff, nxt_state;
  logic [15:0] cw_ff, nxt_cw;
  logic [15:0] mode_sel_ff, nxt_mode_sel;
  logic [15:0] mode_act_ff, nxt_mode_act;
  logic [15:0] status_ff, nxt_status;
  logic [15:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic err_ff, nxt_err;
  logic en_s1_ff, en_s2_ff, en_prev_ff;
  logic fr_s1_ff, fr_s2_ff, fr_prev_ff;
  logic xerr_ff, nxt_xerr;
  logic xend_ff, nxt_xend;
  logic end_pend_ff, nxt_end_pend;
  logic ref_ok_ff, nxt_ref_ok;
  logic qs_by_bus_ff, nxt_qs_by_bus;
  logic start_ff, nxt_start;
  logic halt_ff, nxt_halt;
  logic pse_ff, nxt_pse;
  logic qs_out_ff, nxt_qs_out;
  logic fra_ff, nxt_fra;
  logic warn_hold;

  logic wr_cw, wr_sel, sel_valid;
  logic bus_fault_reset, fault_reset_evt;
  logic cmd_dis_volt, cmd_qstop, cmd_shutdown, cmd_switch_on, cmd_enable_op;
  logic pin_en_rise, pin_en_fall, pin_fr_rise;
  logic halt_req, mode_starts, err_hi, err_qs;

  function automatic logic mode_code_ok(input logic [15:0] code);
    mode_code_ok = (code == `MODE_SPEED) || (code == `MODE_JOG) ||
                   (code == `MODE_PROF_POS) || (code == `MODE_PROF_VEL) ||
                   (code == `MODE_HOMING) || (code == `MODE_CSP);
  endfunction : mode_code_ok

  // Parameter writes are served whoever owns motion
  assign wr_cw = i_par_valid && i_par_write && (i_par_addr == `OFS_CONTROL); // see R3
  assign wr_sel = i_par_valid && i_par_write && (i_par_addr == `OFS_MODE_SEL); // see R3
  assign sel_valid = mode_code_ok(i_par_wdata); // see R18

  // Fault reset on the fieldbus is the 0-to-1 step of bit 7 at write time
  assign bus_fault_reset = i_remote && wr_cw && i_par_wdata[`CW_FAULT_RESET] &&
                           !cw_ff[`CW_FAULT_RESET]; // see R15
  assign pin_en_rise = en_s2_ff && !en_prev_ff; // see R10
  assign pin_en_fall = !en_s2_ff && en_prev_ff; // see R10
  assign pin_fr_rise = !i_remote && fr_s2_ff && !fr_prev_ff; // see R11
  assign fault_reset_evt = bus_fault_reset || pin_fr_rise;

  // Level commands from the stored word, only while the fieldbus has control
  assign cmd_dis_volt = i_remote && !cw_ff[`CW_EN_VOLTAGE]; // see R12, R14
  assign cmd_qstop = i_remote && !cw_ff[`CW_QUICK_STOP] && cw_ff[`CW_EN_VOLTAGE]; // see R15
  assign cmd_shutdown = i_remote && (cw_ff[2:0] == 3'b110); // see R14
  assign cmd_switch_on = i_remote && (cw_ff[3:0] == 4'b0111); // see R14
  assign cmd_enable_op = i_remote && (cw_ff[3:0] == 4'b1111); // see R15
  assign halt_req = i_remote && cw_ff[`CW_HALT]; // see R16

  assign err_hi = i_error_event && (i_error_class >= 3'd2); // see R5
  assign err_qs = i_error_event && (i_error_class == 3'd1); // see R5

  always_comb begin
    nxt_state = state_ff;
    nxt_qs_by_bus = qs_by_bus_ff;
    // Operating state machine
    case (state_ff)
      ST_NOT_READY: begin
        nxt_state = ST_ON_DISABLED;
      end
      ST_ON_DISABLED: begin
        if (!i_remote && pin_en_rise && i_dc_bus_ok) begin
          nxt_state = ST_OP_ENABLED; // see R10
        end else if (cmd_shutdown && i_dc_bus_ok) begin
          nxt_state = ST_READY; // see R14
        end
      end
      ST_READY: begin
        if (cmd_dis_volt || cmd_qstop) begin
          nxt_state = ST_ON_DISABLED; // see R14
        end else if (cmd_enable_op || (!i_remote && pin_en_rise)) begin
          nxt_state = ST_OP_ENABLED; // see R10
        end else if (cmd_switch_on) begin
          nxt_state = ST_SWITCHED_ON; // see R14
        end
      end
      ST_SWITCHED_ON: begin
        if (cmd_dis_volt || cmd_qstop) begin
          nxt_state = ST_ON_DISABLED;
        end else if (cmd_shutdown) begin
          nxt_state = ST_READY;
        end else if (cmd_enable_op || (!i_remote && pin_en_rise)) begin
          nxt_state = ST_OP_ENABLED; // see R15
        end
      end
      ST_OP_ENABLED: begin
        if (cmd_dis_volt || (!i_remote && pin_en_fall)) begin
          nxt_state = ST_ON_DISABLED; // see R10
        end else if (cmd_qstop || err_qs) begin
          nxt_state = ST_QUICK_STOP; // see R15
          nxt_qs_by_bus = cmd_qstop;
        end else if (cmd_shutdown) begin
          nxt_state = ST_READY;
        end else if (cmd_switch_on) begin
          nxt_state = ST_SWITCHED_ON; // see R14
        end
      end
      ST_QUICK_STOP: begin
        if (cmd_dis_volt || (!i_remote && pin_en_fall)) begin
          nxt_state = ST_ON_DISABLED; // see R10
        end else if (fault_reset_evt && !i_error_present) begin
          nxt_state = ST_OP_ENABLED; // see R11
        end else if (cmd_enable_op && qs_by_bus_ff) begin
          nxt_state = ST_OP_ENABLED; // see R15
        end
      end
      ST_FAULT_REACT: begin
        if (i_fault_reaction_done || (err_hi && i_error_class >= 3'd3)) begin
          nxt_state = ST_FAULT; // see R5
        end
      end
      ST_FAULT: begin
        // Reset refused while the cause stands
        if (fault_reset_evt && !i_error_present) begin
          nxt_state = ST_ON_DISABLED; // see R11
        end
      end
      default: begin
        nxt_state = ST_NOT_READY;
      end
    endcase
    if (err_hi && state_ff != ST_FAULT && state_ff != ST_FAULT_REACT) begin
      nxt_state = (i_error_class >= 3'd3) ? ST_FAULT : ST_FAULT_REACT; // see R5
    end
  end

  // A mode starts on entering operation enabled or on a new selection in it
  assign mode_starts = (nxt_state == ST_OP_ENABLED) &&
                       ((state_ff != ST_OP_ENABLED) ||
                        (wr_sel && sel_valid && i_par_wdata != mode_act_ff)); // see R17

  always_comb begin
    nxt_cw = cw_ff;
    nxt_mode_sel = mode_sel_ff;
    nxt_mode_act = mode_act_ff;
    nxt_xerr = xerr_ff;
    nxt_xend = xend_ff;
    nxt_end_pend = end_pend_ff;
    nxt_ref_ok = ref_ok_ff;
    nxt_rdata = rdata_ff;
    nxt_ack = 1'b0;
    nxt_err = 1'b0;
    // Parameter access
    if (wr_cw) begin
      nxt_cw = i_par_wdata & `CW_WRITE_MASK; // see R22
    end
    if (wr_sel && sel_valid) begin
      nxt_mode_sel = i_par_wdata; // see R18
    end
    if (i_par_valid) begin
      nxt_ack = 1'b1;
      case (i_par_addr)
        `OFS_CONTROL: nxt_rdata = cw_ff;
        `OFS_STATUS: begin
          nxt_rdata = status_ff;
          nxt_err = i_par_write;
        end
        `OFS_MODE_SEL: begin
          nxt_rdata = mode_sel_ff;
          nxt_err = i_par_write && !sel_valid;
        end
        `OFS_MODE_ACT: begin
          nxt_rdata = mode_act_ff; // see R19
          nxt_err = i_par_write;
        end
        default: begin
          nxt_rdata = 16'h0000;
          nxt_err = 1'b1;
        end
      endcase
    end
    // Error flag: a new error beats a reset in the same cycle
    if (fault_reset_evt && !i_error_present) begin
      nxt_xerr = 1'b0;
    end
    if (i_error_event && i_error_class != 3'd0) begin
      nxt_xerr = 1'b1; // see R5
    end
    // Motion end tracking
    if (mode_starts) begin
      nxt_mode_act = (wr_sel && sel_valid) ? i_par_wdata : mode_sel_ff; // see R19
      nxt_xend = 1'b0; // see R6
      nxt_end_pend = 1'b0; // see R8
    end else begin
      if (!xend_ff && (i_mode_done || halt_req || state_ff != ST_OP_ENABLED)) begin
        nxt_end_pend = 1'b1;
      end
      if ((end_pend_ff || nxt_end_pend) && i_standstill) begin
        nxt_xend = 1'b1; // see R7
        nxt_end_pend = 1'b0;
      end
    end
    // Zero point survives stage disable; only loss clears it
    if (i_zero_point_lost) begin
      nxt_ref_ok = 1'b0;
    end
    if (i_zero_point_set) begin
      nxt_ref_ok = 1'b1; // see R9
    end
  end

  always_comb begin
    nxt_start = mode_starts;
    nxt_halt = halt_req && (state_ff == ST_OP_ENABLED); // see R16
    nxt_pse = (nxt_state == ST_OP_ENABLED) || (nxt_state == ST_QUICK_STOP) ||
              (nxt_state == ST_FAULT_REACT);
    nxt_qs_out = (state_ff == ST_QUICK_STOP);
    nxt_fra = (nxt_state == ST_FAULT_REACT);
    nxt_status = 16'h0000; // see R22
    case (state_ff)
      ST_ON_DISABLED: nxt_status[`SW_ON_DISABLED] = 1'b1;
      ST_READY: nxt_status[5:0] = 6'b100001;
      ST_SWITCHED_ON: nxt_status[5:0] = 6'b100011;
      ST_OP_ENABLED: nxt_status[5:0] = 6'b100111;
      ST_QUICK_STOP: nxt_status[5:0] = 6'b000111;
      ST_FAULT_REACT: nxt_status[5:0] = 6'b001111;
      ST_FAULT: nxt_status[`SW_FAULT] = 1'b1;
      default: nxt_status[5:0] = 6'b000000;
    endcase // see R20
    nxt_status[`SW_VOLTAGE] = i_dc_bus_ok;
    nxt_status[`SW_WARNING] = warn_hold; // see R21
    nxt_status[`SW_HALT] = halt_req; // see R1
    nxt_status[`SW_REMOTE] = i_remote; // see R2
    nxt_status[`SW_MODE_A] = i_mode_flag_a; // see R4
    nxt_status[`SW_MODE_B] = i_mode_flag_b; // see R4
    nxt_status[`SW_ERROR] = xerr_ff; // see R5
    nxt_status[`SW_END] = xend_ff;
    nxt_status[`SW_REF_OK] = ref_ok_ff; // see R9
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_NOT_READY;
      qs_by_bus_ff <= 1'b0;
      cw_ff <= `CW_RST;
      mode_sel_ff <= `MODE_SEL_RST;
      mode_act_ff <= `MODE_ACT_RST;
      status_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      en_s1_ff <= 1'b0;
      en_s2_ff <= 1'b0;
      en_prev_ff <= 1'b0;
      fr_s1_ff <= 1'b0;
      fr_s2_ff <= 1'b0;
      fr_prev_ff <= 1'b0;
      xerr_ff <= 1'b0;
      xend_ff <= 1'b1;
      end_pend_ff <= 1'b0;
      ref_ok_ff <= 1'b0;
      start_ff <= 1'b0;
      halt_ff <= 1'b0;
      pse_ff <= 1'b0;
      qs_out_ff <= 1'b0;
      fra_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      qs_by_bus_ff <= nxt_qs_by_bus;
      cw_ff <= nxt_cw;
      mode_sel_ff <= nxt_mode_sel;
      mode_act_ff <= nxt_mode_act;
      status_ff <= nxt_status;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      en_s1_ff <= i_enable_pin;
      en_s2_ff <= en_s1_ff;
      en_prev_ff <= en_s2_ff;
      fr_s1_ff <= i_fault_reset_pin;
      fr_s2_ff <= fr_s1_ff;
      fr_prev_ff <= fr_s2_ff;
      xerr_ff <= nxt_xerr;
      xend_ff <= nxt_xend;
      end_pend_ff <= nxt_end_pend;
      ref_ok_ff <= nxt_ref_ok;
      start_ff <= nxt_start;
      halt_ff <= nxt_halt;
      pse_ff <= nxt_pse;
      qs_out_ff <= nxt_qs_out;
      fra_ff <= nxt_fra;
    end
  end

  // Warning stretch; fault reset clears it at once
  warning_hold #(
    .HOLD_CYCLES(WARN_HOLD_CYCLES)
  ) u_warning_hold (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_warn(i_warning_class0),
    .i_clear(fault_reset_evt), // see R21
    .o_hold(warn_hold)
  );

  assign o_par_rdata = rdata_ff;
  assign o_par_ack = ack_ff;
  assign o_par_err = err_ff;
  assign o_status_word = status_ff;
  assign o_mode_active = mode_act_ff;
  assign o_power_stage_en = pse_ff;
  assign o_mode_start = start_ff;
  assign o_halt = halt_ff;
  assign o_quick_stop = qs_out_ff;
  assign o_fault_reaction = fra_ff;
endmodule : drive_state_control_word

// File: drive_state_defines.svh
`ifndef DRIVE_STATE_DEFINES_SVH
`define DRIVE_STATE_DEFINES_SVH

// Parameter addresses
`define OFS_CONTROL 16'h1b02
`define OFS_STATUS 16'h1b04
`define OFS_MODE_SEL 16'h1b06
`define OFS_MODE_ACT 16'h1b08

// Control word fields
`define CW_SWITCH_ON 0
`define CW_EN_VOLTAGE 1
`define CW_QUICK_STOP 2
`define CW_EN_OPERATION 3
`define CW_FAULT_RESET 7
`define CW_HALT 8
`define CW_WRITE_MASK 16'h01ff

// Status word fields
`define SW_READY 0
`define SW_SWITCHED_ON 1
`define SW_OP_ENABLED 2
`define SW_FAULT 3
`define SW_VOLTAGE 4
`define SW_QUICK_STOP 5
`define SW_ON_DISABLED 6
`define SW_WARNING 7
`define SW_HALT 8
`define SW_REMOTE 9
`define SW_MODE_A 10
`define SW_MODE_B 12
`define SW_ERROR 13
`define SW_END 14
`define SW_REF_OK 15

// Operating mode codes
`define MODE_RESERVED 16'h0000
`define MODE_SPEED 16'hfffc
`define MODE_JOG 16'hffff
`define MODE_PROF_POS 16'h0001
`define MODE_PROF_VEL 16'h0003
`define MODE_HOMING 16'h0006
`define MODE_CSP 16'h0008

// Reset values
`define CW_RST 16'h0000
`define MODE_SEL_RST 16'h0001
`define MODE_ACT_RST 16'h0000

// Timing
`define CLK_HZ 20000000
`define WARN_HOLD_MS 100
`define WARN_HOLD_CYCLES (`WARN_HOLD_MS * (`CLK_HZ / 1000))

`endif

// File: drive_state_pkg.sv
package drive_state_pkg;

  typedef enum logic [7:0] {
    ST_NOT_READY = 8'h01,
    ST_ON_DISABLED = 8'h02,
    ST_READY = 8'h04,
    ST_SWITCHED_ON = 8'h08,
    ST_OP_ENABLED = 8'h10,
    ST_QUICK_STOP = 8'h20,
    ST_FAULT_REACT = 8'h40,
    ST_FAULT = 8'h80
  } drive_state_t;

endpackage : drive_state_pkg

// File: warning_hold.sv
`timescale 1ns/1ps
module warning_hold #(
  parameter int unsigned HOLD_CYCLES = 2000000
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Warning level and clear
  input wire logic i_warn,
  input wire logic i_clear,
  // Stretched flag
  output logic o_hold
);
  localparam int unsigned CNT_W = $clog2(HOLD_CYCLES + 1);
  localparam logic [CNT_W-1:0] RELOAD = CNT_W'(HOLD_CYCLES - 1);

  generate
    if (HOLD_CYCLES < 1) begin : bad_hold
      $error("warning_hold: HOLD_CYCLES must be at least 1");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic hold_ff;
  logic nxt_hold;

  // Reload while the warning stands, so the flag outlasts it by the hold time
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_hold = hold_ff;
    if (i_clear) begin
      nxt_cnt = '0;
      nxt_hold = 1'b0;
    end else if (i_warn) begin
      nxt_cnt = RELOAD;
      nxt_hold = 1'b1;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - CNT_W'(1);
      nxt_hold = 1'b1;
    end else begin
      nxt_hold = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= '0;
      hold_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      hold_ff <= nxt_hold;
    end
  end

  assign o_hold = hold_ff;
endmodule : warning_hold

// File: drive_state_sva.sv
`timescale 1ns/1ps
module drive_state_sva (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Watched inputs
  input wire logic i_par_valid,
  input wire logic i_remote,
  input wire logic i_standstill,
  input wire logic i_warning_class0,
  input wire logic i_zero_point_lost,
  // Watched outputs
  input wire logic o_par_ack,
  input wire logic [15:0] o_status_word,
  input wire logic o_power_stage_en,
  input wire logic o_mode_start,
  input wire logic o_halt,
  input wire logic o_fault_reaction
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_ack_in_time: assert property (i_par_valid |=> o_par_ack)
    else $error("access not acknowledged");
  a_halt_shown: assert property (o_halt |-> ##[0:2] o_status_word[8])
    else $error("halt not shown");
  a_remote_drop: assert property ($fell(i_remote) |-> ##[1:3] !o_status_word[9])
    else $error("remote flag stuck");
  a_spare_zero: assert property (!o_status_word[11])
    else $error("reserved status bit set");
  a_run_code: assert property (o_status_word[2] && !o_status_word[3] |->
    o_status_word[1:0] == 2'b11 && !o_status_word[6])
    else $error("bad running state code");
  a_start_end: assert property (o_mode_start |-> ##[1:3] !o_status_word[14])
    else $error("end flag kept at start");
  a_enable_start: assert property ($rose(o_power_stage_en) && !o_fault_reaction |->
    ##[0:2] o_mode_start)
    else $error("mode not started");
  a_end_at_rest: assert property ($rose(o_status_word[14]) && $past(o_status_word[2]) |->
    $past(i_standstill) || $past(i_standstill, 2))
    else $error("end flag without standstill");
  a_warn_shown: assert property ($rose(i_warning_class0) |-> ##[1:4] o_status_word[7])
    else $error("warning flag missing");
  a_ref_kept: assert property ($fell(o_status_word[15]) |->
    $past(i_zero_point_lost) || $past(i_zero_point_lost, 2) || $past(i_zero_point_lost, 3))
    else $error("zero point dropped");

  c_mode_start: cover property (o_mode_start);
  c_halt: cover property (o_halt);
  c_fault: cover property (o_fault_reaction);
endmodule : drive_state_sva

bind drive_state_control_word drive_state_sva u_drive_state_sva (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_par_valid(i_par_valid), .i_remote(i_remote),
  .i_standstill(i_standstill), .i_warning_class0(i_warning_class0),
  .i_zero_point_lost(i_zero_point_lost), .o_par_ack(o_par_ack), .o_status_word(o_status_word),
  .o_power_stage_en(o_power_stage_en), .o_mode_start(o_mode_start), .o_halt(o_halt),
  .o_fault_reaction(o_fault_reaction));

// File: field_master.sv
`timescale 1ns/1ps
module field_master (
  // Clock
  input wire logic i_clk,
  // Answer
  input wire logic i_ack,
  input wire logic i_err,
  input wire logic [15:0] i_rdata,
  // Requests and pins
  output logic o_valid,
  output logic o_write,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_enable_pin,
  output logic o_fault_reset_pin
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
    o_enable_pin = 1'b0;
    o_fault_reset_pin = 1'b0;
  end

  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        input bit raw, output logic [15:0] rd, output logic er, output bit ok);
    int n;
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_write <= wr;
    o_addr <= a;
    o_wdata <= raw ? d : (d & 16'h01ff);
    @(posedge i_clk);
    o_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'b1 && n < 8);
    ok = (i_ack === 1'b1);
    rd = i_rdata;
    er = i_err;
    // Released bus never shows the last value
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : access

  task automatic set_enable(input logic v);
    @(posedge i_clk);
    o_enable_pin <= v;
  endtask : set_enable

  task automatic fault_reset_pulse();
    @(posedge i_clk);
    o_fault_reset_pin <= 1'b1;
    // Long enough to pass the pin synchroniser
    repeat (4) @(posedge i_clk);
    o_fault_reset_pin <= 1'b0;
  endtask : fault_reset_pulse
endmodule : field_master

// File: testbench.sv
`timescale 1ns/1ps
`include "drive_state_defines.svh"
module testbench;
  localparam int WARN = 20;
  localparam logic [15:0] ST_CODE [6] = '{16'h0050, 16'h0031, 16'h0033, 16'h0037, 16'h0017,
    16'h0018};
  localparam logic [15:0] CMDS [10] = '{16'h0006, 16'h0007, 16'h000f, 16'h0007, 16'h000f,
    16'h010f, 16'h000b, 16'h000f, 16'h0006, 16'h0000};
  localparam logic [15:0] MODES [6] = '{16'hfffc, 16'hffff, 16'h0001, 16'h0003, 16'h0006,
    16'h0008};
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic remote = 1'b1;
  logic warn = 1'b0;
  logic err_ev = 1'b0;
  logic [2:0] err_cls = 3'h0;
  logic err_pres = 1'b0;
  logic still = 1'b1;
  logic done_ev = 1'b0;
  logic flag_a = 1'b0;
  logic flag_b = 1'b0;
  logic zp_set = 1'b0;
  logic zp_lost = 1'b0;
  logic par_valid, par_write, par_ack, par_err, en_pin, fr_pin, pwr, qs;
  logic [15:0] par_addr, par_wdata, par_rdata, status, mode_act, msel;
  logic [15:0] last_cw = 16'h0000;
  int error_cnt = 0;
  int total_checks = 0;
  integer seed = 32'hc922c1f2;
  int st = 0;

  always #25 i_clk = ~i_clk;

  field_master u_field_master (.i_clk(i_clk), .i_ack(par_ack), .i_err(par_err),
    .i_rdata(par_rdata), .o_valid(par_valid), .o_write(par_write), .o_addr(par_addr),
    .o_wdata(par_wdata), .o_enable_pin(en_pin), .o_fault_reset_pin(fr_pin));

  drive_state_control_word #(.WARN_HOLD_CYCLES(WARN)) u_drive_state_control_word (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_par_valid(par_valid), .i_par_write(par_write),
    .i_par_addr(par_addr), .i_par_wdata(par_wdata), .o_par_rdata(par_rdata),
    .o_par_ack(par_ack), .o_par_err(par_err), .i_enable_pin(en_pin),
    .i_fault_reset_pin(fr_pin), .i_remote(remote), .i_dc_bus_ok(1'b1),
    .i_warning_class0(warn), .i_error_event(err_ev), .i_error_class(err_cls),
    .i_error_present(err_pres), .i_fault_reaction_done(still), .i_standstill(still),
    .i_mode_done(done_ev), .i_mode_flag_a(flag_a), .i_mode_flag_b(flag_b),
    .i_zero_point_set(zp_set), .i_zero_point_lost(zp_lost), .o_status_word(status),
    .o_mode_active(mode_act), .o_power_stage_en(pwr), .o_mode_start(), .o_halt(),
    .o_quick_stop(qs), .o_fault_reaction());

  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
  endtask : step

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_sw(input logic [15:0] mask, input logic [15:0] exp);
    chk("status word", exp, status & mask);
  endtask : chk_sw

  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input bit raw,
                     input logic [15:0] exp_rd, input logic exp_err);
    logic [15:0] rd;
    logic er;
    bit ok;
    u_field_master.access(wr, a, d, raw, rd, er, ok);
    chk("ack", 16'h0001, {15'h0000, ok});
    chk("error flag", {15'h0000, exp_err}, {15'h0000, er});
    if (!wr) chk("read data", exp_rd, rd);
  endtask : acc

  // State index: 0 off, 1 ready, 2 on, 3 running, 4 quick stop, 5 fault
  function automatic int fb_next(int cur, logic [15:0] cw);
    if (cur == 5) return (cw[7] && !last_cw[7] && !err_pres) ? 0 : 5;
    if (!cw[1]) return 0;
    if (!cw[2]) return (cur == 3 || cur == 4) ? 4 : 0;
    if (!cw[0]) return (cur <= 3) ? 1 : cur;
    if (!cw[3]) return (cur >= 1 && cur <= 3) ? 2 : cur;
    return (cur >= 2) ? 3 : cur;
  endfunction : fb_next

  task automatic cmd(input logic [15:0] cw);
    logic [15:0] e;
    acc(1'b1, `OFS_CONTROL, cw, 1'b0, 16'h0000, 1'b0);
    st = fb_next(st, cw);
    last_cw = cw;
    step(4);
    e = ST_CODE[st] | {2'b00, st == 5, flag_b, 1'b0, flag_a, remote, cw[8] && st == 3, 8'h00};
    chk_sw(16'hbf7f, e);
    chk("power stage", {14'h0000, st == 4, st == 3 || st == 4}, {14'h0000, qs, pwr});
  endtask : cmd

  task automatic raise_error(input logic [2:0] cls);
    @(posedge i_clk);
    err_ev <= 1'b1;
    err_cls <= cls;
    @(posedge i_clk);
    err_ev <= 1'b0;
    step(6);
  endtask : raise_error

  task automatic mode_done();
    @(posedge i_clk);
    done_ev <= 1'b1;
    @(posedge i_clk);
    done_ev <= 1'b0;
  endtask : mode_done

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    step(20000);
    error_cnt++;
    $display("unexpected run length: expected end seen hang");
    complete_run();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    step(4);
    chk_sw(16'hffff, 16'h4250);
    acc(1'b0, `OFS_CONTROL, 16'h0000, 1'b0, 16'h0000, 1'b0);
    acc(1'b0, `OFS_MODE_SEL, 16'h0000, 1'b0, 16'h0001, 1'b0);
    acc(1'b0, 16'h1b00, 16'h0000, 1'b0, 16'h0000, 1'b1);
    acc(1'b1, `OFS_STATUS, 16'h1234, 1'b1, 16'h0000, 1'b1);
    acc(1'b1, `OFS_MODE_ACT, 16'h0001, 1'b1, 16'h0000, 1'b1);
    acc(1'b1, `OFS_CONTROL, 16'hfe00, 1'b1, 16'h0000, 1'b0);
    acc(1'b0, `OFS_CONTROL, 16'h0000, 1'b0, 16'h0000, 1'b0);
    $display("test registers finished");
    for (int i = 0; i < 8; i++) begin
      msel = MODES[$unsigned($random(seed)) % 6];
      acc(1'b1, `OFS_MODE_SEL, msel, 1'b1, 16'h0000, 1'b0);
      acc(1'b0, `OFS_MODE_SEL, 16'h0000, 1'b0, msel, 1'b0);
    end
    acc(1'b1, `OFS_MODE_SEL, 16'h0002, 1'b1, 16'h0000, 1'b1);
    acc(1'b0, `OFS_MODE_SEL, 16'h0000, 1'b0, msel, 1'b0);
    $display("test mode select finished");
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      {flag_a, flag_b} <= 2'($random(seed));
      cmd(CMDS[i]);
    end
    $display("test commands finished");
    cmd(16'h0006);
    cmd(16'h0007);
    cmd(16'h000f);
    chk_sw(16'h4000, 16'h0000);
    chk("active mode", msel, mode_act);
    msel = (msel == 16'h0006) ? 16'h0008 : 16'h0006;
    fork
      acc(1'b1, `OFS_MODE_SEL, msel, 1'b1, 16'h0000, 1'b0);
      mode_done();
    join
    step(4);
    chk("active mode", msel, mode_act);
    chk_sw(16'h4000, 16'h0000);
    @(posedge i_clk);
    still <= 1'b0;
    mode_done();
    step(4);
    chk_sw(16'h4000, 16'h0000);
    @(posedge i_clk);
    still <= 1'b1;
    step(4);
    chk_sw(16'h4000, 16'h4000);
    $display("test end flag finished");
    raise_error({2'b01, 1'($random(seed))});
    st = 5;
    chk_sw(16'h207f, 16'h2018);
    @(posedge i_clk);
    err_pres <= 1'b1;
    cmd(16'h0080);
    @(posedge i_clk);
    err_pres <= 1'b0;
    cmd(16'h0000);
    cmd(16'h0080);
    $display("test fault finished");
    @(posedge i_clk);
    remote <= 1'b0;
    u_field_master.set_enable(1'b1);
    step(8);
    chk_sw(16'h027f, 16'h0037);
    acc(1'b0, `OFS_MODE_ACT, 16'h0000, 1'b0, msel, 1'b0);
    raise_error(3'h1);
    chk_sw(16'h007f, 16'h0017);
    u_field_master.fault_reset_pulse();
    step(8);
    chk_sw(16'h007f, 16'h0037);
    @(posedge i_clk);
    zp_set <= 1'b1;
    @(posedge i_clk);
    zp_set <= 1'b0;
    u_field_master.set_enable(1'b0);
    step(8);
    chk_sw(16'h807f, 16'h8050);
    @(posedge i_clk);
    zp_lost <= 1'b1;
    warn <= 1'b1;
    @(posedge i_clk);
    zp_lost <= 1'b0;
    warn <= 1'b0;
    step(4);
    chk_sw(16'h8080, 16'h0080);
    step(WARN);
    chk_sw(16'h0080, 16'h0000);
    @(posedge i_clk);
    remote <= 1'b1;
    step(4);
    chk_sw(16'h0200, 16'h0200);
    $display("test pins finished");
    complete_run();
  end
endmodule : testbench
